// >>> sdoc_pkg.sv
// shared constants and types for the staged on/off output controller
// assumes a single 10 MHz clock and a 32-bit classic wishbone register bus
package sdoc_pkg;

    // ==========================================================
    // clock and timing
    localparam int CLK_NS     = 100;
    localparam int BLINK_UNIT_NS = 1000000;
    localparam int TICK_CYC   = BLINK_UNIT_NS / CLK_NS;

    // ==========================================================
    // register byte offsets
    localparam logic [7:0] OFS_STAGE0 = 8'h00;
    localparam logic [7:0] OFS_THR0   = 8'h10;
    localparam logic [7:0] OFS_ENA    = 8'h20;
    localparam logic [7:0] OFS_OVR    = 8'h24;
    localparam logic [7:0] OFS_FLT    = 8'h28;
    localparam logic [7:0] OFS_BLINK  = 8'h2C;
    localparam logic [7:0] OFS_STATUS = 8'h30;
    localparam logic [7:0] OFS_ISTAT  = 8'h34;
    localparam logic [7:0] OFS_IMASK  = 8'h38;

    // ==========================================================
    // sizes and field values
    localparam int NSTG     = 4;
    localparam int NSRC     = 8;
    localparam int SRC_W    = 3;
    localparam int VAL_W    = 16;
    localparam int NIRQ     = 4;
    localparam logic [VAL_W-1:0] ANA_HALF  = 16'h8000;
    localparam logic [VAL_W-1:0] BLINK_RST = 16'h01F4;
    localparam logic [SRC_W-1:0] SRC_NONE  = 3'h0;

    // interrupt bit positions
    localparam int IRQ_RISE = 0;
    localparam int IRQ_FALL = 1;
    localparam int IRQ_FLT  = 2;
    localparam int IRQ_OVR  = 3;

    // ==========================================================
    // types
    typedef enum logic [1:0] {
        RESP_NORMAL,
        RESP_INVERSE,
        RESP_LATCH,
        RESP_BLINK
    } sdoc_resp_e;

    typedef enum logic [1:0] {
        FLT_SHUTOFF,
        FLT_VALUE,
        FLT_HOLD
    } sdoc_fresp_e;

    typedef struct packed {
        logic [SRC_W-1:0] src;
        logic             analog;
        sdoc_resp_e       resp;
    } sdoc_stage_s;

    typedef struct packed {
        logic [VAL_W-1:0] max;
        logic [VAL_W-1:0] min;
    } sdoc_thr_s;

    typedef struct packed {
        logic             value;
        logic             resp;
        logic             analog;
        logic [SRC_W-1:0] src;
    } sdoc_gate_s;

    typedef struct packed {
        logic        det_en;
        logic        value;
        sdoc_fresp_e resp;
    } sdoc_fault_s;

endpackage : sdoc_pkg

// >>> sdoc_stage.sv
// one output stage: threshold conversion and response shaping
// assumes tick is a one-cycle pulse once per blink time unit
`timescale 1ns/1ns
module sdoc_stage
(
    input  wire logic                       ref_clk,
    input  wire logic                       rst_n,
    input  wire logic                       tick,
    input  wire sdoc_pkg::sdoc_stage_s      cfg,
    input  wire sdoc_pkg::sdoc_thr_s        thr,
    input  wire logic [sdoc_pkg::VAL_W-1:0] blink_rate,
    input  wire logic                       src_on,
    input  wire logic [sdoc_pkg::VAL_W-1:0] src_val,
    output logic                            cmd,
    output logic                            resp
);

    logic                       ana_r;
    logic                       prev_r;
    logic                       latch_r;
    logic                       blink_r;
    logic [sdoc_pkg::VAL_W-1:0] cnt_r;
    logic                       rise;
    logic                       used;
    logic                       cmd_on;

    assign used = (cfg.src != sdoc_pkg::SRC_NONE);

    // ==========================================================
    // command state
    // threshold with hold band
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            ana_r <= 1'b0;
        else if (src_val <= thr.min)
            ana_r <= 1'b0;
        else if (src_val >= thr.max)
            ana_r <= 1'b1;
    end

    assign cmd_on = used & (cfg.analog ? ana_r : src_on);
    assign rise   = cmd_on & ~prev_r;
    // in RESP_LATCH mode a set latch keeps its stage true
    assign cmd    = cmd_on | (used & latch_r &
                              (cfg.resp == sdoc_pkg::RESP_LATCH));

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            prev_r <= 1'b0;
        else
            prev_r <= cmd_on;
    end

    // ==========================================================
    // response state
    // toggle on rising command
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            latch_r <= 1'b0;
        else if (rise)
            latch_r <= ~latch_r;
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            blink_r <= 1'b0;
            cnt_r   <= '0;
        end
        else if (!cmd_on)
        begin
            blink_r <= 1'b0;
            cnt_r   <= '0;
        end
        else if (rise)
        begin
            blink_r <= 1'b1;
            cnt_r   <= '0;
        end
        else if (tick)
        begin
            // a rate of zero behaves as one unit
            if (cnt_r + 16'h0001 >= blink_rate)
            begin
                blink_r <= ~blink_r;
                cnt_r   <= '0;
            end
            else
                cnt_r <= cnt_r + 16'h0001;
        end
    end

    always_comb
    begin
        unique case (cfg.resp)
            sdoc_pkg::RESP_NORMAL:  resp = cmd_on;
            sdoc_pkg::RESP_INVERSE: resp = ~cmd_on;
            sdoc_pkg::RESP_LATCH:   resp = latch_r;
            sdoc_pkg::RESP_BLINK:   resp = blink_r;
        endcase
    end

endmodule : sdoc_stage

// >>> sdoc_top.sv
// staged on/off output controller with wishbone registers
// assumes sources, faults and feedback error are synchronous to ref_clk
//
// The register addresses and register access over Wishbone were decided locally.
`timescale 1ns/1ns
module sdoc_top
#(
    parameter int TICK_CYC = sdoc_pkg::TICK_CYC
)
(
    input  wire logic                                        ref_clk,
    input  wire logic                                        rst_n,
    input  wire logic                                        wb_cyc_i,
    input  wire logic                                        wb_stb_i,
    input  wire logic                                        wb_we_i,
    input  wire logic [7:0]                                  wb_adr_i,
    input  wire logic [3:0]                                  wb_sel_i,
    input  wire logic [31:0]                                 wb_dat_i,
    output logic [31:0]                                      wb_dat_o,
    output logic                                             wb_ack_o,
    input  wire logic [sdoc_pkg::NSRC-1:0]                   src_on,
    input  wire logic [sdoc_pkg::NSRC-1:0][sdoc_pkg::VAL_W-1:0] src_val,
    input  wire logic [sdoc_pkg::NSRC-1:0]                   src_fault,
    input  wire logic                                        fb_err,
    output logic                                             out_r,
    output logic                                             irq_r
);

    // ==========================================================
    // configuration registers
    sdoc_pkg::sdoc_stage_s [sdoc_pkg::NSTG-1:0] stage_r;
    sdoc_pkg::sdoc_thr_s   [sdoc_pkg::NSTG-1:0] thr_r;
    sdoc_pkg::sdoc_gate_s                       ena_r;
    sdoc_pkg::sdoc_gate_s                       ovr_r;
    sdoc_pkg::sdoc_fault_s                      flt_r;
    logic [sdoc_pkg::VAL_W-1:0]                 blink_r;
    logic [sdoc_pkg::NIRQ-1:0]                  istat_r;
    logic [sdoc_pkg::NIRQ-1:0]                  imask_r;

    logic [sdoc_pkg::NSTG-1:0]                  st_cmd;
    logic [sdoc_pkg::NSTG-1:0]                  st_resp;
    logic [1:0]                                 win;
    logic                                       any_true;
    logic                                       ena_ok;
    logic                                       ovr_act;
    logic                                       fault_any;
    logic                                       out_nxt;
    logic                                       fault_prev_r;
    logic                                       ovr_prev_r;
    logic [15:0]                                tick_cnt_r;
    logic                                       tick_r;
    logic                                       wr;
    logic                                       rd_go;
    logic [sdoc_pkg::NIRQ-1:0]                  ev;

    localparam int STG_W = $bits(sdoc_pkg::sdoc_stage_s);
    localparam int GAT_W = $bits(sdoc_pkg::sdoc_gate_s);
    localparam int FLT_W = $bits(sdoc_pkg::sdoc_fault_s);

    // ==========================================================
    // decode helpers
    function automatic logic gate_level(
        input sdoc_pkg::sdoc_gate_s               g,
        input logic [sdoc_pkg::NSRC-1:0]          on,
        input logic [sdoc_pkg::NSRC-1:0][sdoc_pkg::VAL_W-1:0] val
    );
        logic lvl;
        lvl = g.analog ? (val[g.src] >= sdoc_pkg::ANA_HALF) : on[g.src];
        return lvl;
    endfunction : gate_level

    function automatic logic [31:0] merge(
        input logic [31:0] old,
        input logic [31:0] dat,
        input logic [3:0]  sel
    );
        logic [31:0] res;
        res = old;
        for (int b = 0; b < 4; b++)
            if (sel[b])
                res[b*8 +: 8] = dat[b*8 +: 8];
        return res;
    endfunction : merge

    // ==========================================================
    // blink time base
    // one divider pulse per time unit, shared by all stages
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            tick_cnt_r <= '0;
            tick_r     <= 1'b0;
        end
        else if (tick_cnt_r == 16'(TICK_CYC - 1))
        begin
            tick_cnt_r <= '0;
            tick_r     <= 1'b1;
        end
        else
        begin
            tick_cnt_r <= tick_cnt_r + 16'h0001;
            tick_r     <= 1'b0;
        end
    end

    // ==========================================================
    // stages
    // four independent stages
    generate
        for (genvar s = 0; s < sdoc_pkg::NSTG; s++)
        begin : g_stage
            sdoc_stage u_stage
            (
                .ref_clk    (ref_clk),
                .rst_n      (rst_n),
                .tick       (tick_r),
                .cfg        (stage_r[s]),
                .thr        (thr_r[s]),
                .blink_rate (blink_r),
                .src_on     (src_on[stage_r[s].src]),
                .src_val    (src_val[stage_r[s].src]),
                .cmd        (st_cmd[s]),
                .resp       (st_resp[s])
            );
        end
    endgenerate

    always_comb
    begin
        win      = 2'h0;
        any_true = 1'b0;
        for (int s = 0; s < sdoc_pkg::NSTG; s++)
            if (st_cmd[s])
            begin
                win      = 2'(s);
                any_true = 1'b1;
            end
    end

    // ==========================================================
    // enable, override and fault
    // enable polarity select
    assign ena_ok = (ena_r.src == sdoc_pkg::SRC_NONE) ? 1'b1 :
                    (gate_level(ena_r, src_on, src_val) ^ ena_r.resp);

    assign ovr_act = (ovr_r.src != sdoc_pkg::SRC_NONE) &&
                     (gate_level(ovr_r, src_on, src_val) ^ ovr_r.resp);

    always_comb
    begin
        fault_any = flt_r.det_en & fb_err;
        if (any_true)
            fault_any = fault_any | src_fault[stage_r[win].src];
        if (ena_r.src != sdoc_pkg::SRC_NONE)
            fault_any = fault_any | src_fault[ena_r.src];
        if (ovr_r.src != sdoc_pkg::SRC_NONE)
            fault_any = fault_any | src_fault[ovr_r.src];
    end

    // ==========================================================
    // output command
    // fault, then override, then enable, then stages
    always_comb
    begin
        if (fault_any)
        begin
            unique case (flt_r.resp)
                sdoc_pkg::FLT_SHUTOFF: out_nxt = 1'b0;
                sdoc_pkg::FLT_VALUE:   out_nxt = flt_r.value;
                sdoc_pkg::FLT_HOLD:    out_nxt = out_r;
                default:               out_nxt = 1'b0;
            endcase
        end
        else if (ovr_act)
            out_nxt = ovr_r.value;
        else if (!ena_ok || !any_true)
            out_nxt = 1'b0;
        else
            out_nxt = st_resp[win];
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            out_r <= 1'b0;
        else
            out_r <= out_nxt;
    end

    // ==========================================================
    // events and interrupt
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            fault_prev_r <= 1'b0;
            ovr_prev_r   <= 1'b0;
        end
        else
        begin
            fault_prev_r <= fault_any;
            ovr_prev_r   <= ovr_act;
        end
    end

    always_comb
    begin
        ev                      = '0;
        ev[sdoc_pkg::IRQ_RISE]  = out_nxt & ~out_r;
        ev[sdoc_pkg::IRQ_FALL]  = ~out_nxt & out_r;
        ev[sdoc_pkg::IRQ_FLT]   = fault_any & ~fault_prev_r;
        ev[sdoc_pkg::IRQ_OVR]   = ovr_act & ~ovr_prev_r;
    end

    assign wr = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o;

    // a new event wins over a write-one clear in the same cycle
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            istat_r <= '0;
        else if (wr && wb_adr_i == sdoc_pkg::OFS_ISTAT && wb_sel_i[0])
            istat_r <= (istat_r & ~wb_dat_i[sdoc_pkg::NIRQ-1:0]) | ev;
        else
            istat_r <= istat_r | ev;
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            irq_r <= 1'b0;
        else
            irq_r <= |(istat_r & imask_r);
    end

    // ==========================================================
    // register writes
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            stage_r <= '0;
            thr_r   <= '0;
            ena_r   <= '0;
            ovr_r   <= '0;
            flt_r   <= '0;
            blink_r <= sdoc_pkg::BLINK_RST;
            imask_r <= '0;
        end
        else if (wr)
        begin
            for (int s = 0; s < sdoc_pkg::NSTG; s++)
            begin
                if (wb_adr_i == sdoc_pkg::OFS_STAGE0 + 8'(4 * s))
                    stage_r[s] <= STG_W'(merge(32'(stage_r[s]), wb_dat_i,
                                               wb_sel_i));
                if (wb_adr_i == sdoc_pkg::OFS_THR0 + 8'(4 * s))
                    thr_r[s] <= merge(thr_r[s], wb_dat_i, wb_sel_i);
            end
            unique case (wb_adr_i)
                sdoc_pkg::OFS_ENA:
                    ena_r <= GAT_W'(merge(32'(ena_r), wb_dat_i, wb_sel_i));
                sdoc_pkg::OFS_OVR:
                    ovr_r <= GAT_W'(merge(32'(ovr_r), wb_dat_i, wb_sel_i));
                sdoc_pkg::OFS_FLT:
                    flt_r <= FLT_W'(merge(32'(flt_r), wb_dat_i, wb_sel_i));
                sdoc_pkg::OFS_BLINK:
                    blink_r <= sdoc_pkg::VAL_W'(merge(32'(blink_r), wb_dat_i,
                                                      wb_sel_i));
                sdoc_pkg::OFS_IMASK:
                    imask_r <= sdoc_pkg::NIRQ'(merge(32'(imask_r), wb_dat_i,
                                                     wb_sel_i));
                default:
                    imask_r <= imask_r;
            endcase
        end
    end

    // ==========================================================
    // bus answer: ack one cycle after the request, data registered
    assign rd_go = wb_cyc_i & wb_stb_i & ~wb_ack_o;

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            wb_ack_o <= 1'b0;
        else
            wb_ack_o <= rd_go;
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            wb_dat_o <= '0;
        else if (rd_go && !wb_we_i)
        begin
            wb_dat_o <= '0;
            for (int s = 0; s < sdoc_pkg::NSTG; s++)
            begin
                if (wb_adr_i == sdoc_pkg::OFS_STAGE0 + 8'(4 * s))
                    wb_dat_o <= 32'(stage_r[s]);
                if (wb_adr_i == sdoc_pkg::OFS_THR0 + 8'(4 * s))
                    wb_dat_o <= thr_r[s];
            end
            unique case (wb_adr_i)
                sdoc_pkg::OFS_ENA:    wb_dat_o <= 32'(ena_r);
                sdoc_pkg::OFS_OVR:    wb_dat_o <= 32'(ovr_r);
                sdoc_pkg::OFS_FLT:    wb_dat_o <= 32'(flt_r);
                sdoc_pkg::OFS_BLINK:  wb_dat_o <= 32'(blink_r);
                sdoc_pkg::OFS_STATUS:
                    wb_dat_o <= 32'({ena_ok, ovr_act, fault_any,
                                     any_true, win, out_r});
                sdoc_pkg::OFS_ISTAT:  wb_dat_o <= 32'(istat_r);
                sdoc_pkg::OFS_IMASK:  wb_dat_o <= 32'(imask_r);
                default:              ;
            endcase
        end
    end

endmodule : sdoc_top

// >>> sdoc_props.sv
// checker for the staged output controller: bus, status and interrupt
// assumes it is bound to sdoc_top and sees only that module's ports
`timescale 1ns/1ns
module sdoc_props
#(
    parameter int TICK_CYC = sdoc_pkg::TICK_CYC
)
(
    input wire logic        ref_clk,
    input wire logic        rst_n,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [7:0]  wb_adr_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic        out_r,
    input wire logic        irq_r
);
    // ==============================================================
    // helpers
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    logic req;
    logic st_rd;
    assign req   = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign st_rd = wb_ack_o && !wb_we_i && wb_adr_i == sdoc_pkg::OFS_STATUS;

    // ==============================================================
    // properties
    property p_ack_resp; req |=> wb_ack_o; endproperty
    property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
    property p_ack_cause; wb_ack_o |-> $past(wb_cyc_i && wb_stb_i); endproperty
    property p_dat_hold; !(req && !wb_we_i) |=> $stable(wb_dat_o); endproperty
    property p_unmap_rd;
        req && !wb_we_i && wb_adr_i >= 8'h3C |=> wb_dat_o == 32'h0;
    endproperty
    property p_stat_out;
        req && !wb_we_i && wb_adr_i == sdoc_pkg::OFS_STATUS
            |=> wb_dat_o[0] == $past(out_r);
    endproperty
    property p_none_off;
        st_rd && (wb_dat_o[5:3] == 3'h0 || wb_dat_o[6:4] == 3'h0)
            |-> !out_r;
    endproperty
    property p_rst_quiet; $rose(rst_n) |-> !out_r && !irq_r; endproperty
    // sticky status: only software can take the interrupt away
    property p_irq_clr;
        $fell(irq_r) |-> $past(wb_cyc_i && wb_stb_i && wb_we_i);
    endproperty

    a_ack_resp: assert property (p_ack_resp) else $error("ack missing");
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
    a_ack_cause: assert property (p_ack_cause) else $error("stray ack");
    a_dat_hold: assert property (p_dat_hold) else $error("read data moved");
    a_unmap_rd: assert property (p_unmap_rd) else $error("unmapped not 0");
    a_stat_out: assert property (p_stat_out) else $error("status bit 0");
    a_none_off: assert property (p_none_off) else $error("output not off");
    a_rst_quiet: assert property (p_rst_quiet) else $error("reset outputs");
    a_irq_clr: assert property (p_irq_clr) else $error("irq fell alone");

    c_stat_rd: cover property (st_rd && wb_dat_o[0]);
    c_irq_up: cover property ($rose(irq_r));
    c_out_dn: cover property ($fell(out_r));
endmodule : sdoc_props

bind sdoc_top sdoc_props #(.TICK_CYC(TICK_CYC)) u_sdoc_props
(
    .ref_clk  (ref_clk),
    .rst_n    (rst_n),
    .wb_cyc_i (wb_cyc_i),
    .wb_stb_i (wb_stb_i),
    .wb_we_i  (wb_we_i),
    .wb_adr_i (wb_adr_i),
    .wb_dat_o (wb_dat_o),
    .wb_ack_o (wb_ack_o),
    .out_r    (out_r),
    .irq_r    (irq_r)
);

// >>> sdoc_load.sv
// valve load on the output with a current feedback monitor
// assumes open_load is set by the bench to model a broken coil
`timescale 1ns/1ns
module sdoc_load
(
    input  wire logic ref_clk,
    input  wire logic rst_n,
    input  wire logic out_r,
    input  wire logic open_load,
    output logic      fb_err
);
    // ==============================================================
    // feedback error
    // once seen while driven, held until open_load drops, so the shutoff cannot chatter
    always_ff @(posedge ref_clk or negedge rst_n)
        if (!rst_n || !open_load)
            fb_err <= 1'b0;
        else if (out_r)
            fb_err <= 1'b1;
endmodule : sdoc_load

// >>> sdoc_top_tb.sv
// self-checking bench for the staged output controller
// assumes the bound checker and the load model beside the design
`timescale 1ns/1ns
module sdoc_top_tb;
    logic        ref_clk, rst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
    logic        out_r, irq_r, fb_err, open_load, q, p;
    logic [7:0]  wb_adr_i;
    logic [3:0]  wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o, rng, e32;
    logic [15:0] v;
    logic [1:0]  e2;
    logic [7:0]  src_on, src_fault;
    logic [7:0][15:0] src_val;
    logic [1:0]  out_q[$];
    logic [31:0] rd_q[$];
    logic [15:0] tv[4] = '{16'hC000, 16'h8000, 16'h4000, 16'h8000};
    int          err_count, cmp_count, t;

    sdoc_top #(.TICK_CYC(4)) u_sdoc_top (.ref_clk(ref_clk), .rst_n(rst_n),
        .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .src_on(src_on),
        .src_val(src_val), .src_fault(src_fault), .fb_err(fb_err),
        .out_r(out_r), .irq_r(irq_r));
    sdoc_load u_sdoc_load (.ref_clk(ref_clk), .rst_n(rst_n), .out_r(out_r),
        .open_load(open_load), .fb_err(fb_err));

    // ==============================================================
    // tasks
    task automatic wrap_up;
        $display("errors %0d compares %0d", err_count, cmp_count);
        if (err_count == 0 && cmp_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : wrap_up

    task automatic fail(input string m);
        err_count++;
        $display("Error at %0t: %s", $time, m);
    endtask : fail

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : xs

    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= w;
        wb_adr_i <= a;
        wb_dat_i <= d;
        n = 0;
        do
        begin
            @(posedge ref_clk);
            n++;
        end
        while (wb_ack_o !== 1'b1 && n < 20);
        if (n >= 20)
        begin
            fail("bus timeout");
            wrap_up();
        end
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge ref_clk);
    endtask : wb

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        rd_q.push_back(e);
        wb(1'b0, a, 32'h0);
    endtask : rd

    // output path settles in at most two edges, irq one more
    task automatic chk(input logic [1:0] e);
        repeat (4) @(posedge ref_clk);
        out_q.push_back(e);
        @(posedge ref_clk);
    endtask : chk

    task automatic stg(input int i, input int s, input int a, input int r);
        wb(1'b1, 8'(4 * i), 32'(s * 8 + a * 4 + r));
    endtask : stg

    task automatic clr;
        src_on    <= 8'h00;
        src_fault <= 8'h00;
        open_load <= 1'b0;
        for (int i = 0; i < 11; i++)
            wb(1'b1, 8'(4 * i), 32'h0);
    endtask : clr

    // ==============================================================
    // watchers
    always @(negedge ref_clk)
        if (out_q.size() > 0)
        begin
            e2 = out_q.pop_front();
            cmp_count++;
            if ({irq_r, out_r} !== e2)
                fail("output or interrupt wrong");
        end

    always @(posedge ref_clk)
        if (wb_ack_o === 1'b1 && wb_we_i === 1'b0 && rd_q.size() > 0)
        begin
            e32 = rd_q.pop_front();
            cmp_count++;
            if (wb_dat_o !== e32)
                fail("read data wrong");
        end

    initial
    begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end

    initial
    begin
        repeat (20000) @(posedge ref_clk);
        fail("run too long");
        wrap_up();
    end

    // ==============================================================
    // scenarios
    initial
    begin
        {rst_n, wb_cyc_i, wb_stb_i, wb_we_i, open_load} = 5'h00;
        {wb_adr_i, wb_dat_i, src_on, src_fault} = 56'h0;
        wb_sel_i = 4'hF;
        src_val = '0;
        rng = 32'hD23EAE6A;
        repeat (6) @(posedge ref_clk);
        rst_n <= 1'b1;
        @(posedge ref_clk);
        rd(sdoc_pkg::OFS_BLINK, 32'h1F4);
        rd(sdoc_pkg::OFS_IMASK, 32'h0);
        wb(1'b1, 8'h40, 32'hFFFFFFFF);
        rd(8'h40, 32'h0);
        wb(1'b1, sdoc_pkg::OFS_BLINK, 32'h2);
        for (int r = 0; r < 2; r++)
        begin
            stg(0, 1, 0, r);
            src_on[1] <= 1'b1;
            chk({1'b0, r == 0});
            src_on[1] <= 1'b0;
            chk(2'b00);
        end
        stg(0, 1, 0, 2);
        for (int k = 0; k < 4; k++)
        begin
            src_on[1] <= (k % 2 == 0);
            chk({1'b0, k < 2});
        end
        stg(0, 1, 0, 3);
        src_on[1] <= 1'b1;
        {t, q} = 0;
        repeat (80)
        begin
            @(posedge ref_clk);
            if (out_r !== q)
                t++;
            q = out_r;
        end
        cmp_count++;
        if (t < 9 || t > 11)
            fail("blink rate wrong");
        src_on[1] <= 1'b0;
        chk(2'b00);
        stg(0, 1, 0, 0);
        stg(3, 2, 0, 1);
        src_on <= 8'h06;
        chk(2'b00);
        src_on <= 8'h02;
        chk(2'b01);
        clr();
        stg(0, 3, 1, 0);
        wb(1'b1, sdoc_pkg::OFS_THR0, 32'hC0004000);
        p = 1'b0;
        for (int k = 0; k < 8; k++)
        begin
            rng = xs(rng);
            v = (k < 4) ? tv[k] : rng[15:0];
            src_val[3] <= v;
            src_val[7] <= rng[31:16];
            if (v <= 16'h4000)
                p = 1'b0;
            else if (v >= 16'hC000)
                p = 1'b1;
            chk({1'b0, p});
        end
        clr();
        stg(0, 1, 0, 0);
        src_on[1] <= 1'b1;
        wb(1'b1, sdoc_pkg::OFS_ENA, 32'h4);
        chk(2'b00);
        src_on[4] <= 1'b1;
        chk(2'b01);
        wb(1'b1, sdoc_pkg::OFS_ENA, 32'h14);
        chk(2'b00);
        wb(1'b1, sdoc_pkg::OFS_OVR, 32'h25);
        src_on[5] <= 1'b1;
        chk(2'b01);
        wb(1'b1, sdoc_pkg::OFS_OVR, 32'h35);
        chk(2'b00);
        src_on[5] <= 1'b0;
        chk(2'b01);
        clr();
        stg(0, 1, 0, 1);
        src_on[1] <= 1'b1;
        wb(1'b1, sdoc_pkg::OFS_FLT, 32'h5);
        src_fault[1] <= 1'b1;
        chk(2'b01);
        wb(1'b1, sdoc_pkg::OFS_FLT, 32'h0);
        chk(2'b00);
        clr();
        stg(0, 1, 0, 0);
        src_on[1] <= 1'b1;
        wb(1'b1, sdoc_pkg::OFS_FLT, 32'h2);
        src_fault[1] <= 1'b1;
        chk(2'b01);
        stg(0, 1, 0, 1);
        chk(2'b01);
        src_fault[1] <= 1'b0;
        chk(2'b00);
        wb(1'b1, sdoc_pkg::OFS_FLT, 32'h8);
        stg(0, 1, 0, 0);
        chk(2'b01);
        open_load <= 1'b1;
        chk(2'b00);
        open_load <= 1'b0;
        chk(2'b01);
        src_on <= 8'h00;
        chk(2'b00);
        wb(1'b1, sdoc_pkg::OFS_ISTAT, 32'hF);
        wb(1'b1, sdoc_pkg::OFS_IMASK, 32'h1);
        src_on[1] <= 1'b1;
        chk(2'b11);
        rd(sdoc_pkg::OFS_ISTAT, 32'h1);
        wb(1'b1, sdoc_pkg::OFS_ISTAT, 32'h1);
        chk(2'b01);
        wb(1'b1, sdoc_pkg::OFS_STATUS, 32'h0);
        rd(sdoc_pkg::OFS_STATUS, 32'h49);
        src_on[1] <= 1'b0;
        chk(2'b00);
        rd(sdoc_pkg::OFS_STATUS, 32'h40);
        rd(sdoc_pkg::OFS_ISTAT, 32'h2);
        rst_n <= 1'b0;
        @(posedge ref_clk);
        rst_n <= 1'b1;
        @(posedge ref_clk);
        rd(sdoc_pkg::OFS_BLINK, 32'h1F4);
        chk(2'b00);
        wrap_up();
    end
endmodule : sdoc_top_tb
